// [bench/cpu_ram_model.sv]
// Processor kick source and RAM guard monitor facing the supervisor
module cpu_ram_model (
  input  wire logic        clk,
  input  wire logic        kickOn,
  input  wire logic        floatOn,
  input  wire logic [15:0] kickGap,
  input  wire logic        resetN,
  input  wire logic        ceOutN,
  output logic             kickInput,
  output logic             kickFloat,
  output int               breachCount
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] gapCnt;
  logic        kickLvl;
  logic        noise;
  logic        onS;
  logic        floatS;
  int          lowRun;
  initial begin
    kickLvl = 1'b0;
    noise = 1'b0;
    gapCnt = 16'h0000;
    lowRun = 0;
    breachCount = 0;
    kickInput = 1'b0;
    kickFloat = 1'b0;
    // Sample on the edge, drive just after it
    forever begin
      @(posedge clk);
      onS = kickOn;
      floatS = floatOn;
      lowRun = resetN ? 0 : lowRun + 1;
      if (lowRun > 384 && ceOutN !== 1'b1) begin
        breachCount = breachCount + 1;
      end
      #1;
      if (!onS) begin
        gapCnt = 16'h0000;
      end else if (gapCnt == 16'h0000) begin
        kickLvl = ~kickLvl;
        gapCnt = kickGap - 16'h0001;
      end else begin
        gapCnt = gapCnt - 16'h0001;
      end
      // Floating pin shows a changing level
      noise = ~noise;
      kickFloat = floatS;
      kickInput = floatS ? noise : kickLvl;
    end
  end
endmodule

// [bench/tb_supervisor_watchdog_reset_ce_gate.sv]
// Self-checking bench for the supervisor core
`include "supervisor_defs.svh"
`define CHK(nm, exp, got) begin \
  cmpCount++; \
  if ((got) !== (exp)) begin \
    failCount++; \
    $display("BAD %s exp %0h got %0h", nm, exp, got); \
  end \
end
module tb_supervisor_watchdog_reset_ce_gate;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 4;
  localparam int RST = `RST_TIMEOUT_MS * TICK;
  localparam int SLOW = `WD_SLOW_MS * TICK;
  localparam int FAST = `WD_FAST_MS * TICK;
  localparam int CECUT = `CE_HOLD_NS / `CLK_PERIOD_NS;
  localparam int EXTP = 4;
  logic        clk;
  logic        rst;
  logic        supplyGood;
  logic        supplyBelowBackup;
  logic        timebaseSelect;
  logic        tbLevel;
  logic        extOn;
  logic [1:0]  extCnt = 2'h0;
  logic        timebaseInput;
  logic        powerfailSense;
  logic        ceInN;
  logic        kickInput;
  logic        kickFloat;
  logic        kickOn;
  logic        floatOn;
  logic [15:0] kickGap;
  logic        resetN;
  logic        resetHigh;
  logic        watchdogFaultN;
  logic        ceOutN;
  logic        lowLineN;
  logic        powerfailFlagN;
  logic        backupActive;
  int          breachCount;
  int          failCount;
  int          cmpCount;
  int          cycles = 0;
  supervisor_watchdog_reset_ce_gate #(.TICK_CYCLES(TICK)) supervisor_watchdog_reset_ce_gate_inst (
    .clk(clk), .rst(rst), .supplyGood(supplyGood), .supplyBelowBackup(supplyBelowBackup),
    .kickInput(kickInput), .kickFloat(kickFloat), .timebaseSelect(timebaseSelect),
    .timebaseInput(timebaseInput), .powerfailSense(powerfailSense), .ceInN(ceInN), .resetN(resetN),
    .resetHigh(resetHigh), .watchdogFaultN(watchdogFaultN), .ceOutN(ceOutN), .lowLineN(lowLineN),
    .powerfailFlagN(powerfailFlagN), .backupActive(backupActive));
  cpu_ram_model cpu_ram_model_inst (
    .clk(clk), .kickOn(kickOn), .floatOn(floatOn), .kickGap(kickGap), .resetN(resetN),
    .ceOutN(ceOutN), .kickInput(kickInput), .kickFloat(kickFloat), .breachCount(breachCount));
  // External timebase: four clocks a period
  assign timebaseInput = extOn ? extCnt[1] : tbLevel;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    #1;
    extCnt = extCnt + 2'h1;
  end
  task automatic conclude();
    $display("TB: compares %0d mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      failCount++;
      conclude();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic waitFor(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v && n < lim) begin
      step(1);
      n++;
    end
  endtask
  // Time until a level, within a dozen cycles of the expected figure
  task automatic span(input string nm, ref logic s, input logic v, input int exp);
    int n;
    waitFor(s, v, exp + 40, n);
    `CHK(nm, 1'b1, (n >= exp - 12) && (n <= exp + 12))
  endtask
  // Drop the kick source for one edge so the model toggles right away
  task automatic kickOnce();
    kickOn = 1'b0;
    step(1);
    kickOn = 1'b1;
    step(1);
    kickOn = 1'b0;
  endtask
  initial begin
    rst = 1'b1;
    supplyGood = 1'b0;
    supplyBelowBackup = 1'b0;
    timebaseSelect = 1'b1;
    tbLevel = 1'b1;
    extOn = 1'b0;
    powerfailSense = 1'b1;
    ceInN = 1'b0;
    kickOn = 1'b0;
    floatOn = 1'b0;
    kickGap = 16'h0400;
    failCount = 0;
    cmpCount = 0;
    step(2);
    rst = 1'b0;
    step(20);
    `CHK("resetN", 1'b0, resetN)
    `CHK("resetHigh", 1'b1, resetHigh)
    `CHK("lowLineN", 1'b0, lowLineN)
    `CHK("faultN", 1'b1, watchdogFaultN)
    `CHK("ceOutN", 1'b1, ceOutN)
    supplyGood = 1'b1;
    step(4);
    `CHK("lowLineN", 1'b1, lowLineN)
    `CHK("ceOutN", 1'b1, ceOutN)
    span("stretch", resetN, 1'b1, RST - 4);
    `CHK("resetHigh", 1'b0, resetHigh)
    step(5);
    `CHK("ceOutN", 1'b0, ceOutN)
    ceInN = 1'b1;
    step(4);
    `CHK("ceOutN", 1'b1, ceOutN)
    ceInN = 1'b0;
    step(4);
    `CHK("ceOutN", 1'b0, ceOutN)
    kickOn = 1'b1;
    step(4000);
    powerfailSense = 1'b0;
    step(4);
    `CHK("pfFlagN", 1'b0, powerfailFlagN)
    step(4000);
    `CHK("resetN", 1'b1, resetN)
    `CHK("faultN", 1'b1, watchdogFaultN)
    powerfailSense = 1'b1;
    kickOnce();
    span("wdSlow", watchdogFaultN, 1'b0, SLOW);
    `CHK("resetN", 1'b0, resetN)
    `CHK("resetHigh", 1'b1, resetHigh)
    step(40);
    `CHK("ceOutN", 1'b0, ceOutN)
    span("ceCut", ceOutN, 1'b1, CECUT - 40);
    span("wdPulse", resetN, 1'b1, RST - CECUT);
    `CHK("faultN", 1'b0, watchdogFaultN)
    span("wdRepeat", resetN, 1'b0, SLOW);
    `CHK("faultN", 1'b0, watchdogFaultN)
    ceInN = 1'b1;
    step(4);
    `CHK("ceOutN", 1'b1, ceOutN)
    ceInN = 1'b0;
    step(4);
    `CHK("ceOutN", 1'b1, ceOutN)
    span("pulse2", resetN, 1'b1, RST - 8);
    kickOnce();
    step(4);
    `CHK("faultN", 1'b1, watchdogFaultN)
    floatOn = 1'b1;
    step(8000);
    `CHK("faultN", 1'b1, watchdogFaultN)
    `CHK("resetN", 1'b1, resetN)
    floatOn = 1'b0;
    tbLevel = 1'b0;
    step(4);
    kickOnce();
    span("wdFast", watchdogFaultN, 1'b0, FAST);
    span("rstFast", resetN, 1'b1, RST);
    span("wdFirst", resetN, 1'b0, SLOW);
    supplyGood = 1'b0;
    supplyBelowBackup = 1'b1;
    powerfailSense = 1'b0;
    step(4);
    `CHK("resetN", 1'b0, resetN)
    `CHK("lowLineN", 1'b0, lowLineN)
    `CHK("faultN", 1'b1, watchdogFaultN)
    `CHK("backup", 1'b1, backupActive)
    `CHK("pfFlagN", 1'b0, powerfailFlagN)
    timebaseSelect = 1'b0;
    extOn = 1'b1;
    supplyBelowBackup = 1'b0;
    powerfailSense = 1'b1;
    step(4);
    `CHK("backup", 1'b0, backupActive)
    supplyGood = 1'b1;
    span("rstExt", resetN, 1'b1, `EXT_RST_CLK * EXTP);
    span("wdExtFirst", watchdogFaultN, 1'b0, `EXT_WD_FIRST_CLK * EXTP);
    span("rstExt2", resetN, 1'b1, `EXT_RST_CLK * EXTP);
    kickOnce();
    step(4);
    span("wdExt", watchdogFaultN, 1'b0, `EXT_WD_NORMAL_CLK * EXTP - 4);
    `CHK("breach", 0, breachCount)
    conclude();
  end
endmodule

// [hw/supervisor_defs.svh]
// Timing and count constants for the supervisor block
`ifndef SUPERVISOR_DEFS_SVH
`define SUPERVISOR_DEFS_SVH
`define CLK_PERIOD_NS     40
`define TICK_NS           1000000
`define RST_TIMEOUT_MS    200
`define WD_SLOW_MS        1600
`define WD_FAST_MS        100
`define EXT_WD_NORMAL_CLK 1024
`define EXT_WD_FIRST_CLK  4096
`define EXT_RST_CLK       2048
`define CE_HOLD_NS        15000
`define KICK_PULSE_NS     100
`endif

// [hw/supervisor_pkg.sv]
// Types shared by the supervisor block
package supervisor_pkg;
  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b10
  } state_type;
endpackage

// [hw/supervisor_watchdog_reset_ce_gate.sv]
// Supervisor core: reset stretch, three-level watchdog, chip-enable gate
// Summary of operation
// - Reset while supply bad, then stretch 200ms, or 2048 external clocks
// - Two reset outputs, always mutually inverse
// - Stuck kick past timeout faults and resets
// - Any kick level change restarts timer
// - Floating kick disables the watchdog
// - Supply bad, backup, float force fault high
// - Watchdog timeout gives one reset period
// - Fault stays low until next kick change, supply bad, backup or float
// - Stuck kick gives periodic reset pulses
// - Internal slow mode: 1.6s watchdog, 200ms reset
// - Internal fast mode: 100ms, first 1.6s
// - External clock: 1024, 4096, 2048 clocks
// - Enabled gate passes chip-enable unchanged
// - Disabled gate drives chip-enable high
// - Cut gate on input high or 15us
// - Gate stays disabled through power-up reset
// - Backup decision never drives reset itself
// - Power-fail result isolated from everything
// - Low-line follows supply good three clocks later, no stretch
// - Select high means internal oscillator
`include "supervisor_defs.svh"

module supervisor_watchdog_reset_ce_gate #(
  parameter int TICK_CYCLES = (`TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int DIV_W       = $clog2(TICK_CYCLES),
  parameter int CNT_W       = 13
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic supplyGood,
  input  wire logic supplyBelowBackup,
  input  wire logic kickInput,
  input  wire logic kickFloat,
  input  wire logic timebaseSelect,
  input  wire logic timebaseInput,
  input  wire logic powerfailSense,
  input  wire logic ceInN,
  output logic      resetN,
  output logic      resetHigh,
  output logic      watchdogFaultN,
  output logic      ceOutN,
  output logic      lowLineN,
  output logic      powerfailFlagN,
  output logic      backupActive
);

  localparam int        IN_W      = 8;
  localparam logic [8:0] CE_CYCLES = 9'((`CE_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS);
  localparam int        CE_BOUND  = (`CE_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 2;

  logic [IN_W-1:0]         sync1_ff;
  logic [IN_W-1:0]         sync2_ff;
  logic                    supS;
  logic                    belowS;
  logic                    kickS;
  logic                    floatS;
  logic                    selS;
  logic                    tbS;
  logic                    pfS;
  logic                    ceS;
  logic                    tbPrev_ff;
  logic                    kickPrev_ff;
  logic [DIV_W-1:0]        divCnt_ff;
  logic                    tick;
  logic                    extMode;
  logic                    fastMode;
  logic                    backupNow;
  supervisor_pkg::state_type state_ff;
  supervisor_pkg::state_type nxt_state;
  logic [CNT_W-1:0]        rstCnt_ff;
  logic [CNT_W-1:0]        wdCnt_ff;
  logic [CNT_W-1:0]        wdLim;
  logic [CNT_W-1:0]        rstLim;
  logic                    firstPeriod_ff;
  logic                    wdEnable;
  logic                    kickChange;
  logic                    wdExpire;
  logic                    rstDone;
  logic                    nxt_resetN;
  logic                    resetN_ff;
  logic                    resetHigh_ff;
  logic                    watchdogFaultN_ff;
  logic                    ceEnabled_ff;
  logic [8:0]              ceTimer_ff;
  logic                    ceOutN_ff;
  logic                    lowLineN_ff;
  logic                    powerfailFlagN_ff;
  logic                    backupActive_ff;

  // Watchdog terminal count for the current timebase
  function automatic logic [CNT_W-1:0] wdLimit(input logic ext, input logic fast, input logic first);
    logic [CNT_W-1:0] lim;
    lim = '0;
    if (ext) begin
      lim = first ? CNT_W'(`EXT_WD_FIRST_CLK) : CNT_W'(`EXT_WD_NORMAL_CLK);
    end else if (fast && !first) begin
      lim = CNT_W'(`WD_FAST_MS);
    end else begin
      lim = CNT_W'(`WD_SLOW_MS);
    end
    return lim;
  endfunction

  // Reset stretch terminal count for the current timebase
  function automatic logic [CNT_W-1:0] rstLimit(input logic ext);
    return ext ? CNT_W'(`EXT_RST_CLK) : CNT_W'(`RST_TIMEOUT_MS);
  endfunction

  // Two-stage synchronisers for every pin
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
    end else begin
      sync1_ff <= {ceInN, powerfailSense, timebaseInput, timebaseSelect,
                   kickFloat, kickInput, supplyBelowBackup, supplyGood};
      sync2_ff <= sync1_ff;
    end
  end

  assign supS   = sync2_ff[0];
  assign belowS = sync2_ff[1];
  assign kickS  = sync2_ff[2];
  assign floatS = sync2_ff[3];
  assign selS   = sync2_ff[4];
  assign tbS    = sync2_ff[5];
  assign pfS    = sync2_ff[6];
  assign ceS    = sync2_ff[7];

  assign backupNow = !supS && belowS;
  assign extMode   = !selS;
  assign fastMode  = selS && !tbS;

  // Timebase: internal tick divider or external clock edges
  always_ff @(posedge clk) begin
    if (rst) begin
      divCnt_ff <= '0;
      tbPrev_ff <= 1'b0;
    end else begin
      tbPrev_ff <= tbS;
      if (extMode || divCnt_ff == DIV_W'(TICK_CYCLES - 1)) begin
        divCnt_ff <= '0;
      end else begin
        divCnt_ff <= divCnt_ff + 1'b1;
      end
    end
  end

  assign tick = extMode ? (tbS && !tbPrev_ff) : (divCnt_ff == DIV_W'(TICK_CYCLES - 1));

  assign wdLim  = wdLimit(extMode, fastMode, firstPeriod_ff);
  assign rstLim = rstLimit(extMode);

  // Kick change detection on synchronised samples
  always_ff @(posedge clk) begin
    if (rst) begin
      kickPrev_ff <= 1'b0;
    end else begin
      kickPrev_ff <= kickS;
    end
  end

  assign kickChange = !floatS && (kickS != kickPrev_ff);
  assign wdEnable   = (state_ff == supervisor_pkg::ST_RUN) && supS && !backupNow && !floatS;
  assign wdExpire   = wdEnable && !kickChange && tick && (wdCnt_ff == wdLim - 1'b1);
  assign rstDone    = supS && tick && (rstCnt_ff == rstLim - 1'b1);

  // Reset state machine
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      supervisor_pkg::ST_RUN: begin
        if (!supS || wdExpire) begin
          nxt_state = supervisor_pkg::ST_HOLD;
        end
      end
      supervisor_pkg::ST_HOLD: begin
        if (rstDone) begin
          nxt_state = supervisor_pkg::ST_RUN;
        end
      end
      default: begin
        nxt_state = supervisor_pkg::ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= supervisor_pkg::ST_HOLD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Reset stretch counter, restarted while supply is bad
  always_ff @(posedge clk) begin
    if (rst) begin
      rstCnt_ff <= '0;
    end else if (state_ff != supervisor_pkg::ST_HOLD || !supS || rstDone) begin
      rstCnt_ff <= '0;
    end else if (tick) begin
      rstCnt_ff <= rstCnt_ff + 1'b1;
    end
  end

  // First watchdog period after each reset uses the long count
  always_ff @(posedge clk) begin
    if (rst) begin
      firstPeriod_ff <= 1'b1;
    end else if (state_ff == supervisor_pkg::ST_HOLD) begin
      firstPeriod_ff <= 1'b1;
    end else if (kickChange || wdExpire) begin
      firstPeriod_ff <= 1'b0;
    end
  end

  // Watchdog counter
  always_ff @(posedge clk) begin
    if (rst) begin
      wdCnt_ff <= '0;
    end else if (!wdEnable || kickChange || wdExpire) begin
      wdCnt_ff <= '0;
    end else if (tick) begin
      wdCnt_ff <= wdCnt_ff + 1'b1;
    end
  end

  // Watchdog fault output
  always_ff @(posedge clk) begin
    if (rst) begin
      watchdogFaultN_ff <= 1'b1;
    end else if (!supS || backupNow || floatS) begin
      watchdogFaultN_ff <= 1'b1;
    end else if (wdExpire) begin
      watchdogFaultN_ff <= 1'b0;
    end else if (kickChange) begin
      watchdogFaultN_ff <= 1'b1;
    end
  end

  // Reset outputs from the state machine only; backup state is not an input here
  assign nxt_resetN = (nxt_state == supervisor_pkg::ST_RUN);

  always_ff @(posedge clk) begin
    if (rst) begin
      resetN_ff    <= 1'b0;
      resetHigh_ff <= 1'b1;
    end else begin
      resetN_ff    <= nxt_resetN;
      resetHigh_ff <= !nxt_resetN;
    end
  end

  // Chip-enable gate control
  always_ff @(posedge clk) begin
    if (rst) begin
      ceTimer_ff <= 9'h000;
    end else if (resetN_ff) begin
      ceTimer_ff <= 9'h000;
    end else if (ceTimer_ff != CE_CYCLES) begin
      ceTimer_ff <= ceTimer_ff + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ceEnabled_ff <= 1'b0;
    end else if (nxt_resetN && resetN_ff) begin
      ceEnabled_ff <= 1'b1;
    end else if (!resetN_ff && (ceS || ceTimer_ff >= CE_CYCLES - 1'b1)) begin
      ceEnabled_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ceOutN_ff <= 1'b1;
    end else if (ceEnabled_ff) begin
      ceOutN_ff <= ceS;
    end else begin
      ceOutN_ff <= 1'b1;
    end
  end

  // Side outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      lowLineN_ff       <= 1'b0;
      powerfailFlagN_ff <= 1'b1;
      backupActive_ff   <= 1'b0;
    end else begin
      lowLineN_ff       <= supS;
      powerfailFlagN_ff <= pfS;
      backupActive_ff   <= backupNow;
    end
  end

  assign resetN         = resetN_ff;
  assign resetHigh      = resetHigh_ff;
  assign watchdogFaultN = watchdogFaultN_ff;
  assign ceOutN         = ceOutN_ff;
  assign lowLineN       = lowLineN_ff;
  assign powerfailFlagN = powerfailFlagN_ff;
  assign backupActive   = backupActive_ff;

  // Checks
  property p_inverse;
    @(posedge clk) disable iff (rst) resetHigh_ff == !resetN_ff;
  endproperty
  a_inverse: assert property (p_inverse) else $error("reset outputs not inverse");

  property p_supplyReset;
    @(posedge clk) disable iff (rst) !supS |=> !resetN_ff;
  endproperty
  a_supplyReset: assert property (p_supplyReset) else $error("no reset on bad supply");

  property p_lowLine;
    @(posedge clk) disable iff (rst) ##1 lowLineN_ff == $past(supS);
  endproperty
  a_lowLine: assert property (p_lowLine) else $error("low-line not following supply");

  property p_faultHighDisabled;
    @(posedge clk) disable iff (rst) (!supS || backupNow || floatS) |=> watchdogFaultN_ff;
  endproperty
  a_faultHighDisabled: assert property (p_faultHighDisabled) else $error("fault low while disabled");

  property p_timeoutFault;
    @(posedge clk) disable iff (rst) wdExpire |=> !watchdogFaultN_ff && !resetN_ff && resetHigh_ff;
  endproperty
  a_timeoutFault: assert property (p_timeoutFault) else $error("timeout without fault and reset");

  property p_kickRestart;
    @(posedge clk) disable iff (rst) kickChange |=> wdCnt_ff == '0;
  endproperty
  a_kickRestart: assert property (p_kickRestart) else $error("kick did not restart timer");

  property p_faultHold;
    @(posedge clk) disable iff (rst)
      (!watchdogFaultN_ff && !kickChange && supS && !floatS) |=> !watchdogFaultN_ff;
  endproperty
  a_faultHold: assert property (p_faultHold) else $error("fault released without kick");

  property p_ceFollow;
    @(posedge clk) disable iff (rst) ceEnabled_ff |=> ceOutN_ff == $past(ceS);
  endproperty
  a_ceFollow: assert property (p_ceFollow) else $error("chip-enable not passed");

  property p_ceBlocked;
    @(posedge clk) disable iff (rst) !ceEnabled_ff |=> ceOutN_ff;
  endproperty
  a_ceBlocked: assert property (p_ceBlocked) else $error("chip-enable not held high");

  property p_ceCut;
    @(posedge clk) disable iff (rst) $fell(resetN_ff) |-> ##[0:CE_BOUND] !ceEnabled_ff;
  endproperty
  a_ceCut: assert property (p_ceCut) else $error("gate not cut after reset");

  property p_holdNoCe;
    @(posedge clk) disable iff (rst) (!resetN_ff && !ceEnabled_ff) |=> !ceEnabled_ff;
  endproperty
  a_holdNoCe: assert property (p_holdNoCe) else $error("gate opened during reset");

  c_timeout:   cover property (@(posedge clk) disable iff (rst) wdExpire);
  c_ceByInput: cover property (@(posedge clk) disable iff (rst) !resetN_ff && ceS && $fell(ceEnabled_ff));
  c_ceByTime:  cover property (@(posedge clk) disable iff (rst) !ceS && $fell(ceEnabled_ff));
  c_release:   cover property (@(posedge clk) disable iff (rst) $rose(resetN_ff));

endmodule
